// [src/uvcs_pkg.sv]
// shared constants for the vendor register and statistics request path
package uvcs_pkg;
  localparam logic [7:0]  REQ_TYPE_OUT = 8'h40;
  localparam logic [7:0]  REQ_TYPE_IN  = 8'hc0;
  localparam logic [7:0]  REQ_WRITE    = 8'ha0;
  localparam logic [7:0]  REQ_READ     = 8'ha1;
  localparam logic [7:0]  REQ_STATS    = 8'ha2;
  localparam logic [15:0] REG_LEN      = 16'h0004;
  localparam logic [15:0] STATS_LEN    = 16'h00bc;
  localparam int          ADDR_W       = 13;
  localparam int          NUM_CNT      = 47;
  localparam int          TX_FIRST     = 23;
  localparam logic [13:0] RUNT_LEN     = 14'h0040;
  localparam logic [7:0]  LAST_REG_B   = 8'h03;
  localparam logic [7:0]  LAST_STAT_B  = 8'hbb;
  // counter slots (word index = byte offset / 4)
  localparam int C_RX_FCS = 0;
  localparam int C_RX_ALN = 1;
  localparam int C_RX_FRG = 2;
  localparam int C_RX_JAB = 3;
  localparam int C_RX_UND = 4;
  localparam int C_RX_UBY = 7;
  localparam int C_RX_UFR = 10;
  localparam int C_TX_BAD = 26;
  localparam int C_TX_UBY = 31;
  localparam int C_TX_UFR = 34;
  localparam logic [31:0] MASK_20 = 32'h000f_ffff;
  localparam logic [31:0] MASK_32 = 32'hffff_ffff;
  typedef enum logic [1:0] {UVCS_UNI, UVCS_BC, UVCS_MC} uvcs_cast_t;
  typedef enum logic [1:0] {UVCS_CMD_WR, UVCS_CMD_RD, UVCS_CMD_STATS} uvcs_cmd_t;
  // byte counters and time counters are 32 bits wide, the rest 20
  function automatic logic [31:0] uvcs_mask(input int i);
    if ((i >= C_RX_UBY && i < C_RX_UFR) || i == 22 || i == C_TX_BAD ||
        (i >= C_TX_UBY && i < C_TX_UFR) || i == 46) begin
      return MASK_32;
    end
    return MASK_20;
  endfunction : uvcs_mask
endpackage : uvcs_pkg

// [src/uvcs_if.sv]
// endpoint-0 control transfer link between host end and device end
`timescale 1ns/1ps
interface uvcs_if;
  logic        setup_valid;
  logic        setup_ready;
  logic [7:0]  bm_req_type;
  logic [7:0]  b_request;
  logic [15:0] w_value;
  logic [15:0] w_index;
  logic [15:0] w_length;
  logic        h2d_valid;
  logic        h2d_ready;
  logic [7:0]  h2d_data;
  logic        d2h_valid;
  logic        d2h_ready;
  logic [7:0]  d2h_data;
  logic        xfer_ack;
  logic        xfer_stall;
  modport dev (input setup_valid, bm_req_type, b_request, w_value, w_index, w_length,
               h2d_valid, h2d_data, d2h_ready,
               output setup_ready, h2d_ready, d2h_valid, d2h_data, xfer_ack, xfer_stall);
  modport host (output setup_valid, bm_req_type, b_request, w_value, w_index, w_length,
                h2d_valid, h2d_data, d2h_ready,
                input setup_ready, h2d_ready, d2h_valid, d2h_data, xfer_ack, xfer_stall);
endinterface : uvcs_if

// [src/uvcs_dev.sv]
// device end: vendor register access and statistics counters
// Function
// R01: write request 40h/A0h, wValue 0, wLength 4
// R02: one 32-bit register per write, no increment
// R03: host sends write word at data offset 0
// R04: read request C0h/A1h, wValue 0, wLength 4
// R05: read answers one word in four bytes
// R06: statistics request C0h/A2h, wLength BCh
// R07: all counters frozen at one instant
// R08: counters wrap to zero, never saturate
// R09: suspended auto replies skip transmit counters
// R10: delivered frames counted, bad if store-bad set
// R11: every reset, lite reset too, clears counters
// R12: receive counters occupy slots 00h to 58h
// R13: transmit counters occupy slots 5Ch to B8h
// R14: fcs counter counts crc or symbol errors
// R15: jabber with fcs error counts jabber only
// R16: runt with fcs error counts fragment only
// R17: fragment counts runts with crc/symbol errors
// R18: alignment counter counts flagged frames once
// R19: jabber needs a whole extra byte plus error
// R20: undersize counts clean runts
// R21: narrow counters zero-extended in slot
// R22: words sent least significant byte first
`timescale 1ns/1ps
module uvcs_dev
  import uvcs_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  uvcs_if.dev                    link,
  input  wire logic              lite_reset,
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [31:0]            reg_wdata,
  input  wire logic [31:0]       reg_rdata,
  input  wire logic              rx_done,
  input  wire logic [13:0]       rx_len,
  input  wire logic [13:0]       rx_max_size,
  input  wire logic              rx_crc_err,
  input  wire logic              rx_sym_err,
  input  wire logic              rx_align_err,
  input  wire logic              rx_delivered,
  input  wire logic [1:0]        rx_cast,
  input  wire logic              rx_store_bad,
  input  wire logic              tx_done,
  input  wire logic [13:0]       tx_len,
  input  wire logic [1:0]        tx_cast,
  input  wire logic              tx_auto_reply,
  input  wire logic [NUM_CNT-1:0] stat_evt
);
  typedef enum {ST_IDLE, ST_WDATA, ST_RDREQ, ST_RDWAIT, ST_SEND} uvcs_st_t;

  uvcs_st_t          st_q, st_d;
  logic [7:0]        idx_q, idx_d;
  logic [7:0]        last_q, last_d;
  logic              stats_q, stats_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [31:0]       word_q, word_d;
  logic              wr_q, wr_d;
  logic              ack_q, ack_d;
  logic              stall_q, stall_d;
  logic              snap_go;
  logic [31:0]       cnt_q [NUM_CNT];
  logic [31:0]       cnt_d [NUM_CNT];
  logic [31:0]       snap_q [NUM_CNT];
  logic [31:0]       inc [NUM_CNT];
  logic [31:0]       tx_word;
  logic              is_wr, is_rd, is_st;

  // setup decode
  assign is_wr = link.bm_req_type == REQ_TYPE_OUT && link.b_request == REQ_WRITE &&
                 link.w_value == 16'h0000 && link.w_length == REG_LEN &&
                 link.w_index[15:ADDR_W] == 3'h0; // R01
  assign is_rd = link.bm_req_type == REQ_TYPE_IN && link.b_request == REQ_READ &&
                 link.w_value == 16'h0000 && link.w_length == REG_LEN &&
                 link.w_index[15:ADDR_W] == 3'h0; // R04
  assign is_st = link.bm_req_type == REQ_TYPE_IN && link.b_request == REQ_STATS &&
                 link.w_value == 16'h0000 && link.w_index == 16'h0000 &&
                 link.w_length == STATS_LEN; // R06

  // handshakes and register port
  assign link.setup_ready = st_q == ST_IDLE;
  assign link.h2d_ready   = st_q == ST_WDATA;
  assign link.d2h_valid   = st_q == ST_SEND;
  assign link.xfer_ack    = ack_q;
  assign link.xfer_stall  = stall_q;
  assign reg_wr    = wr_q;
  assign reg_rd    = st_q == ST_RDREQ;
  assign reg_addr  = addr_q; // R02
  assign reg_wdata = word_q;
  assign snap_go   = st_q == ST_IDLE && link.setup_valid && is_st;

  // outgoing byte: frozen slot or read word, low byte first
  assign tx_word       = stats_q ? snap_q[idx_q[7:2]] : word_q; // R12 R13
  assign link.d2h_data = tx_word[{idx_q[1:0], 3'h0} +: 8]; // R22

  // request sequencing
  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    last_d  = last_q;
    stats_d = stats_q;
    addr_d  = addr_q;
    word_d  = word_q;
    wr_d    = 1'b0;
    ack_d   = 1'b0;
    stall_d = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (link.setup_valid) begin
          idx_d  = 8'h00;
          addr_d = link.w_index[ADDR_W-1:0];
          if (is_wr) begin
            st_d = ST_WDATA; // R01
          end else if (is_rd) begin
            st_d = ST_RDREQ; // R04
          end else if (is_st) begin
            st_d    = ST_SEND; // R06
            stats_d = 1'b1;
            last_d  = LAST_STAT_B;
          end else begin
            stall_d = 1'b1;
          end
        end
      end
      ST_WDATA: begin
        if (link.h2d_valid) begin
          word_d[{idx_q[1:0], 3'h0} +: 8] = link.h2d_data; // R03
          idx_d = idx_q + 8'h01;
          if (idx_q == LAST_REG_B) begin
            st_d  = ST_IDLE;
            wr_d  = 1'b1; // R02
            ack_d = 1'b1;
          end
        end
      end
      ST_RDREQ: begin
        st_d = ST_RDWAIT;
      end
      ST_RDWAIT: begin
        word_d  = reg_rdata;
        st_d    = ST_SEND; // R05
        stats_d = 1'b0;
        last_d  = LAST_REG_B;
      end
      ST_SEND: begin
        if (link.d2h_ready) begin
          idx_d = idx_q + 8'h01;
          if (idx_q == last_q) begin
            st_d  = ST_IDLE;
            ack_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q    <= ST_IDLE;
      idx_q   <= 8'h00;
      last_q  <= 8'h00;
      stats_q <= 1'b0;
      addr_q  <= '0;
      word_q  <= 32'h0000_0000;
      wr_q    <= 1'b0;
      ack_q   <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      idx_q   <= idx_d;
      last_q  <= last_d;
      stats_q <= stats_d;
      addr_q  <= addr_d;
      word_q  <= word_d;
      wr_q    <= wr_d;
      ack_q   <= ack_d;
      stall_q <= stall_d;
    end
  end

  // per-counter increments from frame events
  always_comb begin
    logic bad;
    logic runt;
    logic jab;
    bad  = rx_crc_err | rx_sym_err;
    runt = rx_len < RUNT_LEN;
    jab  = rx_len > rx_max_size && bad; // R19
    for (int i = 0; i < NUM_CNT; i++) begin
      inc[i] = {31'h0, stat_evt[i]};
    end
    if (rx_done) begin
      if (bad && !runt && !jab) inc[C_RX_FCS] = inc[C_RX_FCS] + 32'h1; // R14 R15 R16
      if (rx_align_err) inc[C_RX_ALN] = inc[C_RX_ALN] + 32'h1; // R18
      if (runt && bad) inc[C_RX_FRG] = inc[C_RX_FRG] + 32'h1; // R17
      if (jab) inc[C_RX_JAB] = inc[C_RX_JAB] + 32'h1; // R19
      if (runt && !bad && !rx_align_err) inc[C_RX_UND] = inc[C_RX_UND] + 32'h1; // R20
      if (rx_delivered && ((!bad && !rx_align_err) || rx_store_bad)) begin // R10
        inc[C_RX_UBY + int'(rx_cast)] = inc[C_RX_UBY + int'(rx_cast)] + {18'h0, rx_len};
        inc[C_RX_UFR + int'(rx_cast)] = inc[C_RX_UFR + int'(rx_cast)] + 32'h1;
      end
    end
    if (tx_done) begin
      inc[C_TX_UBY + int'(tx_cast)] = inc[C_TX_UBY + int'(tx_cast)] + {18'h0, tx_len};
      inc[C_TX_UFR + int'(tx_cast)] = inc[C_TX_UFR + int'(tx_cast)] + 32'h1;
    end
    if (tx_auto_reply) begin
      for (int i = TX_FIRST; i < NUM_CNT; i++) begin
        inc[i] = 32'h0; // R09
      end
    end
  end

  // counters and snapshot copies
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    always_comb begin
      cnt_d[g] = lite_reset ? 32'h0 : (cnt_q[g] + inc[g]) & uvcs_mask(g); // R08 R11 R21
    end
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        cnt_q[g]  <= 32'h0; // R11
        snap_q[g] <= 32'h0;
      end else begin
        cnt_q[g] <= cnt_d[g];
        if (snap_go) begin
          snap_q[g] <= cnt_q[g]; // R07
        end
      end
    end
  end
endmodule : uvcs_dev

// [src/uvcs_host.sv]
// host end: issues vendor write, read and statistics transfers
`timescale 1ns/1ps
module uvcs_host
  import uvcs_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  uvcs_if.host                   link,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire uvcs_cmd_t         cmd_kind,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [31:0]       cmd_wdata,
  output logic                   rsp_valid,
  output logic                   rsp_stall,
  output logic [31:0]            rsp_data,
  output logic                   stat_valid,
  output logic [5:0]             stat_index,
  output logic [31:0]            stat_word
);
  typedef enum {HS_IDLE, HS_SETUP, HS_WOUT, HS_RIN, HS_WAIT} uvcs_hst_t;

  uvcs_hst_t  st_q, st_d;
  uvcs_cmd_t  kind_q, kind_d;
  logic [12:0] addr_q, addr_d;
  logic [31:0] word_q, word_d;
  logic [7:0]  idx_q, idx_d;
  logic        rv_q, rv_d, rs_q, rs_d, sv_q, sv_d;
  logic [5:0]  si_q, si_d;

  assign cmd_ready   = st_q == HS_IDLE;
  assign link.setup_valid = st_q == HS_SETUP;
  assign link.bm_req_type = kind_q == UVCS_CMD_WR ? REQ_TYPE_OUT : REQ_TYPE_IN; // R01 R04
  assign link.b_request   = kind_q == UVCS_CMD_WR ? REQ_WRITE :
                            kind_q == UVCS_CMD_RD ? REQ_READ : REQ_STATS; // R06
  assign link.w_value     = 16'h0000;
  assign link.w_index     = kind_q == UVCS_CMD_STATS ? 16'h0000 : {3'h0, addr_q};
  assign link.w_length    = kind_q == UVCS_CMD_STATS ? STATS_LEN : REG_LEN;
  assign link.h2d_valid   = st_q == HS_WOUT;
  assign link.h2d_data    = word_q[{idx_q[1:0], 3'h0} +: 8]; // R03
  assign link.d2h_ready   = st_q == HS_RIN;
  assign rsp_valid  = rv_q;
  assign rsp_stall  = rs_q;
  assign rsp_data   = word_q;
  assign stat_valid = sv_q;
  assign stat_index = si_q;
  assign stat_word  = word_q;

  // transfer sequencing and little-endian word assembly
  always_comb begin
    st_d   = st_q;
    kind_d = kind_q;
    addr_d = addr_q;
    word_d = word_q;
    idx_d  = idx_q;
    rv_d   = 1'b0;
    rs_d   = 1'b0;
    sv_d   = 1'b0;
    si_d   = si_q;
    unique case (st_q)
      HS_IDLE: begin
        if (cmd_valid) begin
          st_d   = HS_SETUP;
          kind_d = cmd_kind;
          addr_d = cmd_addr;
          word_d = cmd_wdata;
          idx_d  = 8'h00;
        end
      end
      HS_SETUP: begin
        if (link.setup_ready) begin
          st_d = kind_q == UVCS_CMD_WR ? HS_WOUT : HS_RIN;
        end
      end
      HS_WOUT: begin
        if (link.h2d_ready) begin
          idx_d = idx_q + 8'h01;
          if (idx_q == LAST_REG_B) st_d = HS_WAIT;
        end
      end
      HS_RIN: begin
        if (link.d2h_valid) begin
          word_d[{idx_q[1:0], 3'h0} +: 8] = link.d2h_data; // R22
          idx_d = idx_q + 8'h01;
          if (idx_q[1:0] == 2'h3 && kind_q == UVCS_CMD_STATS) begin
            sv_d = 1'b1;
            si_d = idx_q[7:2];
          end
          if (idx_q == (kind_q == UVCS_CMD_STATS ? LAST_STAT_B : LAST_REG_B)) begin
            st_d = HS_WAIT;
          end
        end
      end
      HS_WAIT: begin
        if (link.xfer_ack) begin
          st_d = HS_IDLE;
          rv_d = 1'b1;
        end
      end
    endcase
    if (st_q != HS_IDLE && link.xfer_stall) begin
      st_d = HS_IDLE;
      rv_d = 1'b1;
      rs_d = 1'b1;
      sv_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q   <= HS_IDLE;
      kind_q <= UVCS_CMD_WR;
      addr_q <= '0;
      word_q <= 32'h0000_0000;
      idx_q  <= 8'h00;
      rv_q   <= 1'b0;
      rs_q   <= 1'b0;
      sv_q   <= 1'b0;
      si_q   <= 6'h00;
    end else begin
      st_q   <= st_d;
      kind_q <= kind_d;
      addr_q <= addr_d;
      word_q <= word_d;
      idx_q  <= idx_d;
      rv_q   <= rv_d;
      rs_q   <= rs_d;
      sv_q   <= sv_d;
      si_q   <= si_d;
    end
  end
endmodule : uvcs_host

// [tb/uvcs_monitor.sv]
// checker watching the endpoint-0 link between host end and device end
`timescale 1ns/1ps
module uvcs_monitor
  import uvcs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        setup_valid,
  input wire logic        setup_ready,
  input wire logic [7:0]  bm_req_type,
  input wire logic [7:0]  b_request,
  input wire logic [15:0] w_value,
  input wire logic [15:0] w_index,
  input wire logic [15:0] w_length,
  input wire logic        h2d_valid,
  input wire logic        h2d_ready,
  input wire logic        d2h_valid,
  input wire logic        d2h_ready,
  input wire logic [7:0]  d2h_data,
  input wire logic        xfer_ack,
  input wire logic        xfer_stall
);
  logic       take;
  logic       is_wr;
  logic       is_rd;
  logic       is_st;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       st_q;
  logic       st_d;
  // decode of the offered setup fields
  assign take  = setup_valid && setup_ready;
  assign is_wr = bm_req_type == REQ_TYPE_OUT && b_request == REQ_WRITE && w_value == 16'h0
                 && w_index[15:13] == 3'h0 && w_length == REG_LEN;
  assign is_rd = bm_req_type == REQ_TYPE_IN && b_request == REQ_READ && w_value == 16'h0
                 && w_index[15:13] == 3'h0 && w_length == REG_LEN;
  assign is_st = bm_req_type == REQ_TYPE_IN && b_request == REQ_STATS && w_value == 16'h0
                 && w_index == 16'h0 && w_length == STATS_LEN;
  // bytes moved in the current data stage
  always_comb begin
    cnt_d = cnt_q;
    st_d  = st_q;
    if (take) begin
      cnt_d = 8'h00;
      st_d  = is_st;
    end else if ((d2h_valid && d2h_ready) || (h2d_valid && h2d_ready)) begin
      cnt_d = cnt_q + 8'h01;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      st_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      st_q  <= st_d;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_write_opens_data: assert property (take && is_wr |=> h2d_ready)
    else $error("write setup not followed by data ready");
  a_read_data_three: assert property (take && is_rd |-> ##3 d2h_valid)
    else $error("read data not offered three cycles after setup");
  a_stats_data_next: assert property (take && is_st |=> d2h_valid)
    else $error("statistics data not offered after setup");
  a_bad_setup_stall: assert property (take && !(is_wr || is_rd || is_st) |=> xfer_stall)
    else $error("malformed setup not stalled");
  a_write_ack_bound: assert property (take && is_wr |-> ##[5:60] xfer_ack)
    else $error("write transfer not completed in time");
  a_ack_byte_count: assert property (xfer_ack |-> cnt_q == (st_q ? 8'hbc : 8'h04))
    else $error("data stage length wrong at completion");
  a_d2h_data_hold: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("outgoing byte changed before taken");
  a_busy_after_take: assert property (take && (is_wr || is_rd || is_st) |=> !setup_ready)
    else $error("device idle right after accepting setup");
  a_ack_stall_apart: assert property (!(xfer_ack && xfer_stall))
    else $error("ack and stall together");
  c_write: cover property (take && is_wr);
  c_read: cover property (take && is_rd);
  c_stats: cover property (take && is_st);
  c_refused: cover property (take && !(is_wr || is_rd || is_st));
endmodule : uvcs_monitor

// [tb/usb_vendor_csr_stats_cmd_tb_top.sv]
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ps
module usb_vendor_csr_stats_cmd_tb_top import uvcs_pkg::*;;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic              lite_reset, reg_wr, reg_rd, rx_done, rx_crc_err, rx_sym_err;
  logic              rx_align_err, rx_delivered, rx_store_bad, tx_done, tx_auto_reply;
  logic [ADDR_W-1:0] reg_addr, cmd_addr;
  logic [31:0]       reg_wdata, reg_rdata, cmd_wdata, rsp_data, stat_word;
  logic [13:0]       rx_len, rx_max_size, tx_len;
  logic [1:0]        rx_cast, tx_cast;
  logic [NUM_CNT-1:0] stat_evt;
  logic              cmd_valid, cmd_ready, rsp_valid, rsp_stall, stat_valid;
  uvcs_cmd_t         cmd_kind;
  logic [5:0]        stat_index;
  logic [31:0]       mem [0:8191];
  logic [31:0]       got [0:46];
  logic [31:0]       exp [0:46];
  logic [7:0]        byte_q [$];
  int                wr_cnt = 0;
  int                num_errors = 0;
  int                num_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  uvcs_if bus ();
  uvcs_dev u_uvcs_dev (.ref_clk, .rst, .link(bus), .lite_reset, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .rx_done, .rx_len, .rx_max_size, .rx_crc_err, .rx_sym_err,
    .rx_align_err, .rx_delivered, .rx_cast, .rx_store_bad, .tx_done, .tx_len, .tx_cast,
    .tx_auto_reply, .stat_evt);
  uvcs_host u_uvcs_host (.ref_clk, .rst, .link(bus), .cmd_valid, .cmd_ready, .cmd_kind,
    .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_stall, .rsp_data, .stat_valid, .stat_index,
    .stat_word);
  uvcs_monitor u_uvcs_monitor (.ref_clk(ref_clk), .rst(rst), .setup_valid(bus.setup_valid),
    .setup_ready(bus.setup_ready), .bm_req_type(bus.bm_req_type), .b_request(bus.b_request),
    .w_value(bus.w_value), .w_index(bus.w_index), .w_length(bus.w_length),
    .h2d_valid(bus.h2d_valid), .h2d_ready(bus.h2d_ready), .d2h_valid(bus.d2h_valid),
    .d2h_ready(bus.d2h_ready), .d2h_data(bus.d2h_data), .xfer_ack(bus.xfer_ack),
    .xfer_stall(bus.xfer_stall));
  // register space behind the device end, plus capture of returned words and bytes
  always @(posedge ref_clk) begin
    if (reg_wr) begin
      mem[reg_addr] <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (reg_rd) reg_rdata <= mem[reg_addr];
    if (stat_valid) got[stat_index] <= stat_word;
    if (bus.d2h_valid && bus.d2h_ready) byte_q.push_back(bus.d2h_data);
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one host command, entered and finished at falling edges
  task automatic do_cmd(input uvcs_cmd_t k, input logic [12:0] a, input logic [31:0] d);
    int n;
    cmd_kind = k;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    for (n = 0; n < 400 && cmd_ready !== 1'b1; n++) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 400 && rsp_valid !== 1'b1; n++) @(negedge ref_clk);
    chk({31'h0, rsp_valid}, 32'h1);
    chk({31'h0, rsp_stall}, {31'h0, k == uvcs_cmd_t'(2'h3)});
  endtask : do_cmd
  task automatic stats_cmp();
    for (int i = 0; i < NUM_CNT; i++) got[i] = 32'hdead_beef;
    do_cmd(UVCS_CMD_STATS, 13'h0, 32'h0);
    @(negedge ref_clk);
    for (int i = 0; i < NUM_CNT; i++) chk(got[i], exp[i]);
  endtask : stats_cmp
  task automatic rx_frame(input int len, input logic c, s, al, dl, input logic [1:0] ca);
    {rx_crc_err, rx_sym_err, rx_align_err, rx_delivered, rx_cast} = {c, s, al, dl, ca};
    rx_len = 14'(len);
    rx_done = 1'b1;
    @(negedge ref_clk);
    rx_done = 1'b0;
    @(negedge ref_clk);
  endtask : rx_frame
  task automatic tx_frame(input int len, input logic auto_q);
    tx_len = 14'(len);
    tx_auto_reply = auto_q;
    tx_done = 1'b1;
    @(negedge ref_clk);
    {tx_done, tx_auto_reply} = 2'b00; // auto reply is a per-frame qualifier
    @(negedge ref_clk);
  endtask : tx_frame
  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // watchdog against a hung handshake
  initial begin
    #500us;
    num_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    {lite_reset, rx_done, rx_crc_err, rx_sym_err, rx_align_err, rx_delivered} = 6'h0;
    {rx_store_bad, tx_done, tx_auto_reply, cmd_valid, rx_cast, tx_cast} = 8'h0;
    {rx_len, tx_len, cmd_addr, cmd_wdata, reg_rdata, stat_evt} = '0;
    cmd_kind = UVCS_CMD_WR;
    rx_max_size = 14'h05ee;
    for (int i = 0; i < 8192; i++) mem[i] = 32'h0;
    for (int i = 0; i < NUM_CNT; i++) exp[i] = 32'h0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    do_cmd(UVCS_CMD_WR, 13'h1abc, 32'h89ab_cdef);
    chk(mem[13'h1abc], 32'h89ab_cdef);
    chk(mem[13'h1abd], 32'h0);
    chk(32'(wr_cnt), 32'h1);
    byte_q.delete();
    do_cmd(UVCS_CMD_RD, 13'h1abc, 32'h0);
    chk(rsp_data, 32'h89ab_cdef);
    chk({byte_q[3], byte_q[2], byte_q[1], byte_q[0]}, 32'h89ab_cdef);
    chk(32'(byte_q.size()), 32'h4);
    // unused command code gives a setup matching no request: refused, no write
    do_cmd(uvcs_cmd_t'(2'h3), 13'h0, 32'h0);
    chk(32'(wr_cnt), 32'h1);
    rx_frame(100, 1, 0, 0, 0, 0);
    rx_frame(1518, 0, 1, 0, 0, 0);
    rx_frame(1519, 1, 0, 0, 0, 0);
    rx_frame(63, 1, 0, 0, 0, 0);
    rx_frame(40, 0, 1, 0, 0, 0);
    rx_frame(63, 0, 0, 0, 0, 0);
    rx_frame(64, 0, 0, 0, 0, 0);
    rx_frame(100, 0, 0, 1, 0, 0);
    rx_frame(100, 0, 0, 0, 1, 0);
    rx_frame(80, 1, 0, 0, 1, 1);
    rx_store_bad = 1'b1;
    rx_frame(90, 1, 0, 0, 1, 2);
    tx_frame(60, 0);
    tx_frame(70, 1);
    stat_evt = 47'h4000_0000_2000;
    @(negedge ref_clk);
    stat_evt = '0;
    {exp[0], exp[1], exp[2], exp[3], exp[4]} = {32'd4, 32'd1, 32'd2, 32'd1, 32'd1};
    {exp[7], exp[9], exp[10], exp[12], exp[13]} = {32'd100, 32'd90, 32'd1, 32'd1, 32'd1};
    {exp[31], exp[34], exp[46]} = {32'd60, 32'd1, 32'd1};
    fork
      stats_cmp();
      begin
        repeat (20) @(negedge ref_clk);
        rx_frame(100, 1, 0, 0, 0, 0);
      end
    join
    exp[0] = 32'd5;
    stats_cmp();
    lite_reset = 1'b1;
    stat_evt[0] = 1'b1;
    @(negedge ref_clk);
    {lite_reset, stat_evt} = '0;
    for (int i = 0; i < NUM_CNT; i++) exp[i] = 32'h0;
    stats_cmp();
    rx_frame(100, 1, 0, 0, 0, 0);
    exp[0] = 32'd1;
    stats_cmp();
    exp[0] = 32'd0;
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    stats_cmp();
    wrap_up();
  end
endmodule : usb_vendor_csr_stats_cmd_tb_top
